// [verilog/dcr_pkg.sv]
// Purpose: constants for the dac clock, reset and pin front end
// Assumes: 8-bit registers reached by a 7-bit index
// Notes:   same index map for the register port and the serial port
package dcr_pkg;
	// ---------------------------------------------------------------
	// register indices
	// ---------------------------------------------------------------
	localparam logic [6:0] IDX_CHAN_DIS  = 7'h08;
	localparam logic [6:0] IDX_CLK_CTRL  = 7'h09;
	localparam logic [6:0] IDX_GPO_SEL   = 7'h0A;
	localparam logic [6:0] IDX_GPO_VAL   = 7'h0B;
	localparam logic [6:0] IDX_STATE     = 7'h0C;
	localparam logic [6:0] IDX_INT_STAT  = 7'h0D;
	localparam logic [6:0] IDX_INT_CLR   = 7'h0E;
	localparam logic [6:0] IDX_INT_EN    = 7'h0F;
	// ---------------------------------------------------------------
	// fields and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] CHAN_DIS_MASK = 8'h3C;
	localparam logic [7:0] CHAN_DIS_RST  = 8'h00;
	localparam int         CLK_HALF_BIT  = 0;
	localparam int         CLK_EN_BIT    = 1;
	localparam logic [7:0] CLK_CTRL_RST  = 8'h02;
	localparam logic [7:0] CLK_CTRL_MASK = 8'h03;
	localparam logic [5:0] GPO_RST       = 6'h00;
	localparam int         EV_INIT_DONE  = 0;
	localparam int         EV_ALL_SILENT = 1;
	localparam int         EV_MCLK_LOST  = 2;
	localparam int         EV_FRAME      = 3;
	localparam int         EV_W          = 4;
	// ---------------------------------------------------------------
	// serial control word
	// ---------------------------------------------------------------
	localparam logic [4:0] SER_HDR_LAST  = 5'd7;
	localparam logic [4:0] SER_WORD_BITS = 5'd16;
	localparam int         SER_RW_BIT    = 15;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int         INIT_MCLKS    = 1024;
	localparam int         MCLK_LOST_NS  = 80;
	localparam int         CLK_PERIOD_NS = 5;
	localparam int         MCLK_LOST_CYC = MCLK_LOST_NS / CLK_PERIOD_NS;
	typedef enum logic {dcr_st_init, dcr_st_run} dcr_state_t;
endpackage : dcr_pkg

// [verilog/dcr_front_end.sv]
// Purpose: clock, reset and pin front end of a six-channel audio dac
// Assumes: all pins asynchronous to clock; master clock below 100 MHz
// Notes:   pins are sampled by clock and their edges found in logic
// Notes on behaviour
// - Converters run only while the master clock is running.
// - The buffered clock out runs at master rate or half of it.
// - Reset is active low; low resets, high lets the block run.
// - Input a feeds channels 1-2, b feeds 3-4, c feeds 5-6.
// - The all-silent flag is the AND of the six channel flags.
// - Readback leaves on the serial out pin, undriven otherwise.
// - A set disable bit for channels 3 to 6 stops that converter.
// - Control bits pick clock out rate and enable; enabled at reset.
// - After reset 1024 master clocks pass before writes and converters start.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module dcr_front_end import dcr_pkg::*; #(
	parameter int SAMPLE_W   = 24,
	parameter int INIT_COUNT = INIT_MCLKS
) (
	input  wire logic                     clock,
	input  wire logic                     rst_n,
	input  wire logic [6:0]               reg_addr,
	input  wire logic [7:0]               reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [7:0]               reg_rdata,
	output logic                          irq,
	input  wire logic                     master_clock_in,
	output logic                          buffered_clock_out,
	input  wire logic                     word_select_clock,
	input  wire logic                     audio_bit_clock,
	input  wire logic                     audio_in_a,
	input  wire logic                     audio_in_b,
	input  wire logic                     audio_in_c,
	output logic      [5:0][SAMPLE_W-1:0] chan_sample,
	output logic      [5:0]               chan_active,
	output logic      [5:0]               silence_flag,
	output logic                          silence_flag_all,
	input  wire logic                     ctrl_shift_clock,
	input  wire logic                     ctrl_latch_enable,
	input  wire logic                     ctrl_serial_in,
	output logic                          ctrl_serial_out,
	output logic                          ctrl_serial_out_en
);
	if (SAMPLE_W < 16 || SAMPLE_W > 32 || INIT_COUNT < 2)
		$error("dcr_front_end: unsupported parameter values");

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	localparam int PW = 9;
	logic [PW-1:0] pin_s1, pin_s2, pin_s3;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
		end else begin
			pin_s1 <= {ctrl_serial_in, ctrl_latch_enable, ctrl_shift_clock,
				audio_in_c, audio_in_b, audio_in_a, audio_bit_clock,
				word_select_clock, master_clock_in};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
		end
	end
	wire mclk_rise = pin_s2[0] & ~pin_s3[0];
	wire ws_rise   = pin_s2[1] & ~pin_s3[1];
	wire ws_fall   = ~pin_s2[1] & pin_s3[1];
	wire bck_rise  = pin_s2[2] & ~pin_s3[2];
	wire sck_rise  = pin_s2[6] & ~pin_s3[6];
	wire sck_fall  = ~pin_s2[6] & pin_s3[6];
	wire latch_hi  = pin_s2[7];
	wire latch_rise = pin_s2[7] & ~pin_s3[7];

	// ---------------------------------------------------------------
	// initialisation and master clock watch
	// ---------------------------------------------------------------
	dcr_state_t state;
	logic [10:0] init_cnt;
	logic [4:0]  lost_cnt;
	logic        mclk_alive;
	wire running = (state == dcr_st_run);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state    <= dcr_st_init;
			init_cnt <= '0;
		end else begin
			case (state)
			dcr_st_init: if (mclk_rise) begin
				if (init_cnt == 11'(INIT_COUNT - 1))
					state <= dcr_st_run;
				init_cnt <= init_cnt + 11'd1;
			end
			dcr_st_run: state <= dcr_st_run;
			default: state <= dcr_st_init;
			endcase
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lost_cnt   <= '0;
			mclk_alive <= 1'b0;
		end else if (mclk_rise) begin
			lost_cnt   <= '0;
			mclk_alive <= 1'b1;
		end else if (lost_cnt == 5'(MCLK_LOST_CYC)) begin
			mclk_alive <= 1'b0;
		end else begin
			lost_cnt <= lost_cnt + 5'd1;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [7:0]      chan_dis, clk_ctrl;
	logic [5:0]      gpo_sel, gpo_val;
	logic [EV_W-1:0] int_stat, int_en, ev;
	logic [5:0]      next_flag;
	logic            next_all;
	logic [15:0]     ser_sr;
	logic [4:0]      ser_cnt;
	wire  ser_commit = latch_rise && ser_cnt == SER_WORD_BITS &&
		!ser_sr[SER_RW_BIT];
	// bus write wins over a serial commit in the same cycle
	wire       wr_any = running && (reg_wr || ser_commit);
	wire [6:0] wr_idx = reg_wr ? reg_addr : ser_sr[14:8];
	wire [7:0] wr_dat = reg_wr ? reg_wdata : ser_sr[7:0];

	function automatic logic [7:0] reg_read(input logic [6:0] idx);
		case (idx)
		IDX_CHAN_DIS: reg_read = chan_dis;
		IDX_CLK_CTRL: reg_read = clk_ctrl;
		IDX_GPO_SEL:  reg_read = {2'b00, gpo_sel};
		IDX_GPO_VAL:  reg_read = {2'b00, gpo_val};
		IDX_STATE:    reg_read = {mclk_alive, running, silence_flag};
		IDX_INT_STAT: reg_read = {4'h0, int_stat};
		IDX_INT_EN:   reg_read = {4'h0, int_en};
		default:      reg_read = 8'h00;
		endcase
	endfunction : reg_read

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			chan_dis <= CHAN_DIS_RST;
			clk_ctrl <= CLK_CTRL_RST;
			gpo_sel  <= GPO_RST;
			gpo_val  <= GPO_RST;
			int_en   <= '0;
		end else if (wr_any) begin
			case (wr_idx)
			IDX_CHAN_DIS: chan_dis <= wr_dat & CHAN_DIS_MASK;
			IDX_CLK_CTRL: clk_ctrl <= wr_dat & CLK_CTRL_MASK;
			IDX_GPO_SEL:  gpo_sel  <= wr_dat[5:0];
			IDX_GPO_VAL:  gpo_val  <= wr_dat[5:0];
			IDX_INT_EN:   int_en   <= wr_dat[EV_W-1:0];
			default:      int_en   <= int_en;
			endcase
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= reg_rd ? reg_read(reg_addr) : 8'h00;
	end

	// ---------------------------------------------------------------
	// interrupts
	// ---------------------------------------------------------------
	logic [EV_W-1:0] clr;
	logic            was_running, was_alive;
	always_comb begin
		clr = '0;
		if (wr_any && wr_idx == IDX_INT_CLR)
			clr = wr_dat[EV_W-1:0];
		ev = '0;
		ev[EV_INIT_DONE]  = running & ~was_running;
		ev[EV_ALL_SILENT] = next_all & ~silence_flag_all;
		ev[EV_MCLK_LOST]  = was_alive & ~mclk_alive;
		ev[EV_FRAME]      = running & ws_rise;
	end
	// set wins over clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			int_stat    <= '0;
			irq         <= 1'b0;
			was_running <= 1'b0;
			was_alive   <= 1'b0;
		end else begin
			int_stat    <= (int_stat & ~clr) | ev;
			irq         <= |(((int_stat & ~clr) | ev) & int_en);
			was_running <= running;
			was_alive   <= mclk_alive;
		end
	end

	// ---------------------------------------------------------------
	// buffered clock out
	// ---------------------------------------------------------------
	logic half_clk;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			half_clk           <= 1'b0;
			buffered_clock_out <= 1'b0;
		end else begin
			if (mclk_rise)
				half_clk <= ~half_clk;
			if (!clk_ctrl[CLK_EN_BIT])
				buffered_clock_out <= 1'b0;
			else if (clk_ctrl[CLK_HALF_BIT])
				buffered_clock_out <= half_clk ^ mclk_rise;
			else
				buffered_clock_out <= pin_s2[0];
		end
	end

	// ---------------------------------------------------------------
	// audio capture and routing
	// ---------------------------------------------------------------
	logic [2:0][SAMPLE_W-1:0] shift;
	logic [5:0] dis;
	assign dis = chan_dis[5:0];
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			shift <= '0;
		else if (bck_rise)
			for (int i = 0; i < 3; i++)
				shift[i] <= {shift[i][SAMPLE_W-2:0], pin_s2[3+i]};
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			chan_sample <= '0;
			chan_active <= '0;
		end else begin
			for (int i = 0; i < 6; i++) begin
				chan_active[i] <= running & mclk_alive & ~dis[i];
				if (!running || dis[i])
					chan_sample[i] <= '0;
				else if ((i % 2 == 0) ? ws_fall : ws_rise)
					chan_sample[i] <= shift[i/2];
			end
		end
	end

	// ---------------------------------------------------------------
	// silence flags
	// ---------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 6; i++)
			next_flag[i] = gpo_sel[i] ? gpo_val[i] :
				(chan_sample[i] == '0);
		next_all = &next_flag;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			silence_flag     <= '0;
			silence_flag_all <= 1'b0;
		end else begin
			silence_flag     <= next_flag;
			silence_flag_all <= next_all;
		end
	end

	// ---------------------------------------------------------------
	// serial control port
	// ---------------------------------------------------------------
	logic       rd_mode;
	logic [7:0] rd_sh;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ser_sr  <= '0;
			ser_cnt <= '0;
		end else if (latch_hi) begin
			ser_cnt <= latch_rise ? ser_cnt : '0;
			if (!latch_rise)
				ser_sr <= ser_sr;
		end else if (sck_rise && ser_cnt != SER_WORD_BITS) begin
			ser_sr  <= {ser_sr[14:0], pin_s2[8]};
			ser_cnt <= ser_cnt + 5'd1;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_mode            <= 1'b0;
			rd_sh              <= '0;
			ctrl_serial_out    <= 1'b0;
			ctrl_serial_out_en <= 1'b0;
		end else if (latch_hi) begin
			rd_mode            <= 1'b0;
			ctrl_serial_out    <= 1'b0;
			ctrl_serial_out_en <= 1'b0;
		end else if (sck_rise && ser_cnt == SER_HDR_LAST && ser_sr[6]) begin
			rd_mode            <= 1'b1;
			rd_sh              <= reg_read({ser_sr[5:0], pin_s2[8]});
			ctrl_serial_out_en <= 1'b1;
		end else if (sck_fall && rd_mode) begin
			ctrl_serial_out <= rd_sh[7];
			rd_sh           <= {rd_sh[6:0], 1'b0};
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_init_hold_defaults: assert property (
		!running |=> chan_active == '0 && clk_ctrl == CLK_CTRL_RST)
		else $error("registers left defaults during init");
	a_init_length_exact: assert property (
		$rose(running) |-> $past(init_cnt) == 11'(INIT_COUNT - 1))
		else $error("init ended after wrong master clock count");
	a_no_clock_idle: assert property (
		!mclk_alive |=> chan_active == '0)
		else $error("converter active without master clock");
	a_half_rate_toggle: assert property (
		clk_ctrl[CLK_EN_BIT] && clk_ctrl[CLK_HALF_BIT] && mclk_rise
		&& $stable(clk_ctrl) |=> buffered_clock_out != $past(half_clk))
		else $error("half rate clock out failed to toggle");
	a_clk_out_off: assert property (
		!clk_ctrl[CLK_EN_BIT] |=> !buffered_clock_out)
		else $error("clock out driven while disabled");
	a_route_input_b: assert property (
		running && ws_fall && !dis[2] |=> chan_sample[2] == $past(shift[1]))
		else $error("input b left word not routed to channel 3");
	a_disable_chan_six: assert property (
		dis[5] |=> chan_sample[5] == '0 ##0 !chan_active[5])
		else $error("disabled channel 6 still running");
	a_all_silent_and: assert property (
		silence_flag_all == &silence_flag)
		else $error("all-silent flag differs from and of flags");
	a_silent_all_zero: assert property (
		chan_sample == '0 && gpo_sel == '0 |=> silence_flag_all)
		else $error("all-silent flag low with every channel zero");
	a_readback_release: assert property (
		latch_hi |=> !ctrl_serial_out_en [*2])
		else $error("serial out driven outside a read frame");
	a_gpo_level_out: assert property (
		gpo_sel[0] && $stable(gpo_val) |=> silence_flag[0] == $past(gpo_val[0]))
		else $error("general output level not shown on flag 1");
endmodule : dcr_front_end

// [tb/dcr_audio_src.sv]
// Purpose: audio source and master clock beside the front end
// Assumes: 64 ns master clock, bit clock at half of it
// Notes:   sample sits in the last bits of each 32-bit slot
`timescale 1ns/1ps
module dcr_audio_src #(
	parameter int W    = 16,
	parameter int SLOT = 32
) (
	input  wire logic              mclk_on,
	input  wire logic [5:0][W-1:0] smp,
	output logic                   master_clock_in,
	output logic                   audio_bit_clock,
	output logic                   word_select_clock,
	output logic                   audio_in_a,
	output logic                   audio_in_b,
	output logic                   audio_in_c
);
	logic [5:0][W-1:0] held;

	initial begin
		master_clock_in = 1'b0;
		forever #32 master_clock_in = mclk_on & ~master_clock_in;
	end

	// one word select period per sample, 64 bits
	initial begin
		audio_bit_clock = 1'b0;
		word_select_clock = 1'b1;
		held = smp;
		{audio_in_a, audio_in_b, audio_in_c} = 3'h0;
		forever begin
			for (int h = 0; h < 2; h++) begin
				for (int i = SLOT - 1; i >= 0; i--) begin
					word_select_clock = (h == 0);
					if (h == 0 && i == SLOT - 1)
						held = smp;
					// pad bits toggle so stale slot bits show
					if (i < W)
						{audio_in_a, audio_in_b, audio_in_c} =
							{held[h][i], held[2+h][i], held[4+h][i]};
					else
						{audio_in_a, audio_in_b, audio_in_c} = {3{i[0]}};
					@(posedge master_clock_in);
					audio_bit_clock = 1'b1;
					@(posedge master_clock_in);
					audio_bit_clock = 1'b0;
				end
			end
		end
	end
endmodule : dcr_audio_src

// [tb/tb.sv]
// Purpose: self-checking bench for the dac front end
// Assumes: init count of 8, 16-bit samples
// Notes:   read data checked by a monitor from a queue
`timescale 1ns/1ps
module tb import dcr_pkg::*; ;
	localparam int W = 16;
	logic              clock, rst_n, reg_wr, reg_rd, mclk_on, rd_d;
	logic [6:0]        reg_addr;
	logic [7:0]        reg_wdata, reg_rdata, got;
	logic [15:0]       lfsr;
	logic [15:0]       exp_q[$];
	logic [5:0][W-1:0] chan_sample, smp;
	logic [5:0]        chan_active, silence_flag;
	logic              irq, buffered_clock_out, master_clock_in;
	logic              word_select_clock, audio_bit_clock, silence_flag_all;
	logic              audio_in_a, audio_in_b, audio_in_c;
	logic              ctrl_shift_clock, ctrl_latch_enable, ctrl_serial_in;
	logic              ctrl_serial_out, ctrl_serial_out_en;
	wire               ctrl_serial_wire;
	int                n_fail, n_compared;

	dcr_front_end #(.SAMPLE_W(W), .INIT_COUNT(8)) dut (
		.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .irq, .master_clock_in, .buffered_clock_out,
		.word_select_clock, .audio_bit_clock, .audio_in_a, .audio_in_b,
		.audio_in_c, .chan_sample, .chan_active, .silence_flag,
		.silence_flag_all, .ctrl_shift_clock, .ctrl_latch_enable,
		.ctrl_serial_in, .ctrl_serial_out, .ctrl_serial_out_en
	);
	dcr_audio_src #(.W(W)) src (
		.mclk_on, .smp, .master_clock_in, .audio_bit_clock,
		.word_select_clock, .audio_in_a, .audio_in_b, .audio_in_c
	);
	assign ctrl_serial_wire = ctrl_serial_out_en ? ctrl_serial_out : 1'bz;

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr_next

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic chk_cnt(input int g, input int e);
		n_compared++;
		if (g < e - 1 || g > e + 1) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_cnt

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		cyc(1);
		reg_wr <= 1'b0;
		cyc(1);
	endtask : wr

	task automatic rd(input logic [6:0] a, input logic [7:0] e,
		input logic [7:0] m);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back({m, e});
		cyc(1);
		reg_rd <= 1'b0;
		cyc(1);
	endtask : rd

	// read data stands only in the cycle after the strobe
	always @(posedge clock) begin
		if (rd_d === 1'b1) begin
			chk(reg_rdata & exp_q[0][15:8], exp_q[0][7:0]);
			exp_q.delete(0);
		end
		rd_d <= reg_rd;
	end

	task automatic count_rise(input int e);
		int   n;
		logic p;
		n = 0;
		p = buffered_clock_out;
		repeat (256) begin
			@(posedge clock);
			n += int'(buffered_clock_out & ~p);
			p = buffered_clock_out;
		end
		chk_cnt(n, e);
	endtask : count_rise

	task automatic rand_smp();
		for (int i = 0; i < 6; i++) begin
			lfsr = lfsr_next(lfsr);
			smp[i] = lfsr;
		end
	endtask : rand_smp

	task automatic chk_smp(input logic [5:0] dis);
		for (int i = 0; i < 6; i++)
			chk(chan_sample[i], dis[i] ? 32'h0 : smp[i]);
	endtask : chk_smp

	task automatic frames(input int n);
		repeat (n) @(negedge word_select_clock);
		cyc(12);
	endtask : frames

	// serial frame; read bits follow each falling shift clock
	task automatic ser(input logic [15:0] w, input int n);
		ctrl_latch_enable <= 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			ctrl_serial_in <= w[i];
			cyc(8);
			ctrl_shift_clock <= 1'b1;
			cyc(8);
			ctrl_shift_clock <= 1'b0;
			cyc(8);
			if (i >= 1 && i <= 8)
				got[i-1] = ctrl_serial_wire;
			if (i == 1)
				chk(ctrl_serial_out_en, w[15]);
		end
		ctrl_serial_in <= 1'b0;
		ctrl_latch_enable <= 1'b1;
		cyc(8);
		chk(ctrl_serial_wire, 1'bz);
	endtask : ser

	task automatic wrap_up();
		$display("fails=%0d compares=%0d", n_fail, n_compared);
		if (n_fail == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up

	initial begin
		#400000;
		n_fail++;
		wrap_up();
	end

	// ---------------------------------------------------------------
	// sequence
	// ---------------------------------------------------------------
	initial begin
		{rst_n, reg_wr, reg_rd, ctrl_shift_clock} = 4'h0;
		{reg_addr, reg_wdata, ctrl_serial_in, smp} = '0;
		ctrl_latch_enable = 1'b1;
		mclk_on = 1'b1;
		lfsr = 16'h004D;
		n_fail = 0;
		n_compared = 0;
		cyc(4);
		rst_n <= 1'b1;
		cyc(1);
		rd(IDX_STATE, 8'h00, 8'h40);
		wr(IDX_CLK_CTRL, 8'h00);
		count_rise(20);
		cyc(100);
		rd(IDX_STATE, 8'h40, 8'h40);
		rd(IDX_CLK_CTRL, CLK_CTRL_RST, 8'hFF);
		rd(IDX_INT_STAT, 8'h01, 8'h01);
		wr(IDX_CHAN_DIS, 8'hFF);
		rd(IDX_CHAN_DIS, CHAN_DIS_MASK, 8'hFF);
		rd(7'h10, 8'h00, 8'hFF);
		rd(IDX_INT_CLR, 8'h00, 8'hFF);
		wr(IDX_CLK_CTRL, 8'h03);
		count_rise(10);
		wr(IDX_CLK_CTRL, 8'h01);
		count_rise(0);
		wr(IDX_CLK_CTRL, 8'h02);
		wr(IDX_CHAN_DIS, 8'h00);
		wr(IDX_INT_CLR, 8'h0F);
		wr(IDX_INT_EN, 8'h08);
		rand_smp();
		frames(3);
		chk_smp(6'h00);
		chk(silence_flag_all, 1'b0);
		chk(irq, 1'b1);
		wr(IDX_INT_EN, 8'h00);
		cyc(1);
		chk(irq, 1'b0);
		wr(IDX_INT_CLR, 8'h08);
		rd(IDX_INT_STAT, 8'h00, 8'h08);
		wr(IDX_CHAN_DIS, 8'h3C);
		rand_smp();
		frames(3);
		chk_smp(6'h3C);
		chk(chan_active, 6'h03);
		wr(IDX_CHAN_DIS, 8'h00);
		smp = '0;
		frames(3);
		chk(silence_flag, 6'h3F);
		chk(silence_flag_all, 1'b1);
		smp[5] = 16'h0001;
		frames(3);
		chk(silence_flag, 6'h1F);
		chk(silence_flag_all, 1'b0);
		wr(IDX_GPO_SEL, 8'h21);
		wr(IDX_GPO_VAL, 8'h20);
		cyc(1);
		chk(silence_flag, 6'h3E);
		wr(IDX_GPO_VAL, 8'h21);
		cyc(1);
		chk(silence_flag, 6'h3F);
		chk(silence_flag_all, 1'b1);
		mclk_on = 1'b0;
		cyc(60);
		chk(chan_active, 6'h00);
		rd(IDX_INT_STAT, 8'h04, 8'h04);
		mclk_on = 1'b1;
		cyc(40);
		ser({1'b0, IDX_CHAN_DIS, 8'h24}, 16);
		rd(IDX_CHAN_DIS, 8'h24, 8'hFF);
		chk(chan_active, 6'h1B);
		ser({1'b0, IDX_CHAN_DIS, 8'h00}, 15);
		rd(IDX_CHAN_DIS, 8'h24, 8'hFF);
		ser({1'b1, IDX_CLK_CTRL, 8'h00}, 16);
		chk(got, CLK_CTRL_RST);
		wr(IDX_CLK_CTRL, 8'h03);
		rst_n <= 1'b0;
		cyc(3);
		chk(buffered_clock_out, 1'b0);
		chk(chan_active, 6'h00);
		rst_n <= 1'b1;
		cyc(1);
		rd(IDX_CLK_CTRL, CLK_CTRL_RST, 8'hFF);
		cyc(4);
		wrap_up();
	end
endmodule : tb
